// [smb_slave_port.sv]
// Purpose: smbus 2.0 slave port: addressing, udid, pointer, byte and block transfers
// Assumes: host drives scl; strap_level digitised and stable at reset release
// Notes:   register file outside; only the block read count is held here
//
// Notes on behaviour
// - strap levels 4..7 pick arp-capable mode, levels 0..3 fixed-discoverable
// - fixed mode address is 0x50 plus strap level
// - arp mode vendor field carries strap code and 16-bit random value
// - udid top byte is capabilities 11000001
// - udid holds version, vendor id and device id constants
// - udid interface field reads 0x0004
// - subsystem vendor and device fields read zero
// - fixed mode ignores assign-address, keeps strap address
// - start is sda falling with scl high, then eight bits msb first
// - matching address is acked on ninth clock, otherwise stay idle
// - bytes are nine clocks; sda rising with scl high is stop
// - direction is set by address byte; change needs new start
// - first written byte loads pointer, later bytes go to pointed register
// - reads return the register held in the pointer
// - pointer msb selects block access to low seven bits register
// - block read length comes from count register at 0x00
// - block write length is the count sent by the host
// - send-byte, write-byte and block-write are accepted
// - send-byte: address and register byte are both acked
// - strap sampled once after each reset release, later changes ignored
// - random part generated on chip, free running from reset until the first start
// - arp commands carry a pec byte
// - pec is crc-8 with polynomial x^8+x^2+x+1
module smb_slave_port #(
  parameter logic [7:0]  UDID_VERSION = 8'h11, // arbitrary value
  parameter logic [15:0] UDID_VENDOR  = 16'h1234, // arbitrary value
  parameter logic [15:0] UDID_DEVICE  = 16'h5678  // arbitrary value
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic [2:0]   strap_level,
  input  wire logic         assign_valid,
  input  wire logic [6:0]   assign_addr,
  output logic              arp_mode,
  output logic [6:0]        own_addr,
  output logic [127:0]      udid,
  output logic [6:0]        reg_raddr,
  input  wire logic [7:0]   reg_rdata,
  output logic              reg_we,
  output logic [6:0]        reg_waddr,
  output logic [7:0]        reg_wdata,
  output logic [7:0]        register_pointer,
  output logic [7:0]        block_read_byte_count,
  output logic              pec_ok
);

  smb_line_if line ();

  smb_line_sampler u_sampler (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .line    (line)
  );

  // ---------------------------------------------------------------
  // crc-8 step, used for the running pec
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ smb_pkg::CRC_POLY) : (c << 1);
    return c;
  endfunction

  // ---------------------------------------------------------------
  // strap capture and mode
  // ---------------------------------------------------------------
  logic       strap_done;
  logic [2:0] strap_id_bits;

  // caught once after reset release; the strap is not watched afterwards
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      strap_done    <= 1'b0;
      strap_id_bits <= 3'h0;
    end
    else if (!strap_done)
    begin
      strap_done    <= 1'b1;
      strap_id_bits <= strap_level;
    end
  end

  assign arp_mode = strap_id_bits >= smb_pkg::STRAP_ARP_MIN;

  // fixed mode ignores assignment so a host cannot move it by mistake
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      own_addr <= smb_pkg::ARP_ADDR_RESET;
    // wait for the captured strap, else arp mode would keep a fixed address
    else if (strap_done && !arp_mode)
      own_addr <= smb_pkg::FD_ADDR_BASE + {4'h0, strap_id_bits};
    else if (assign_valid)
      own_addr <= assign_addr;
  end

  // ---------------------------------------------------------------
  // random part of the vendor field
  // ---------------------------------------------------------------
  logic [15:0] lfsr;
  logic        rand_frozen;

  // free running until the first start; host timing supplies the spread
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lfsr        <= smb_pkg::LFSR_SEED;
      rand_frozen <= 1'b0;
    end
    else if (!rand_frozen)
    begin
      lfsr        <= lfsr[0] ? ((lfsr >> 1) ^ smb_pkg::LFSR_TAPS) : (lfsr >> 1);
      rand_frozen <= line.start;
    end
  end

  assign udid = {smb_pkg::UDID_CAPS,
                 UDID_VERSION, UDID_VENDOR, UDID_DEVICE,
                 smb_pkg::UDID_INTERFACE,
                 smb_pkg::UDID_SUBSYS, smb_pkg::UDID_SUBSYS,
                 smb_pkg::UDID_VS_PAD, (arp_mode ? strap_id_bits : 3'h0), lfsr};

  // ---------------------------------------------------------------
  // transfer engine
  // ---------------------------------------------------------------
  smb_pkg::smb_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       is_read;
  logic [7:0] byte_idx;
  logic [7:0] blk_len;
  logic [6:0] cur_addr;
  logic       host_ack;
  logic       byte_done;
  logic       got8;
  logic       more_rd;
  logic [7:0] tx_byte;

  assign got8      = bit_cnt == smb_pkg::BITS_PER_BYTE;
  assign byte_done = line.scl_fall & got8 & (state == smb_pkg::SMB_ADDR || state == smb_pkg::SMB_WR);
  assign reg_raddr = cur_addr;
  assign sda_out   = 1'b0;
  assign tx_byte   = (register_pointer[7] && byte_idx == 8'h00) ? block_read_byte_count :
                     (cur_addr == smb_pkg::REG_BLOCK_COUNT) ? block_read_byte_count : reg_rdata;
  assign more_rd   = !register_pointer[7] || byte_idx <= block_read_byte_count;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state            <= smb_pkg::SMB_IDLE;
      bit_cnt          <= 4'h0;
      shreg            <= 8'h00;
      is_read          <= 1'b0;
      byte_idx         <= 8'h00;
      blk_len          <= 8'h00;
      cur_addr         <= 7'h00;
      host_ack         <= 1'b0;
      sda_oe           <= 1'b0;
      register_pointer <= 8'h00;
      reg_we           <= 1'b0;
      reg_waddr        <= 7'h00;
      reg_wdata        <= 8'h00;
    end
    else
    begin
      reg_we <= 1'b0;
      if (line.start)
      begin
        state    <= smb_pkg::SMB_ADDR;
        bit_cnt  <= 4'h0;
        byte_idx <= 8'h00;
        sda_oe   <= 1'b0;
      end
      else if (line.stop)
      begin
        state  <= smb_pkg::SMB_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        unique case (state)
          smb_pkg::SMB_IDLE, smb_pkg::SMB_SKIP:
            sda_oe <= 1'b0;
          smb_pkg::SMB_ADDR:
          begin
            if (line.scl_rise)
            begin
              shreg   <= {shreg[6:0], line.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (line.scl_fall && got8)
            begin
              if (shreg[7:1] == own_addr)
              begin
                state   <= smb_pkg::SMB_ACK;
                sda_oe  <= 1'b1;
                is_read <= shreg[0];
              end
              else
                state <= smb_pkg::SMB_SKIP;
            end
          end
          smb_pkg::SMB_ACK:
          begin
            if (line.scl_fall)
            begin
              if (is_read)
              begin
                shreg    <= tx_byte;
                sda_oe   <= ~tx_byte[7];
                bit_cnt  <= 4'h1;
                byte_idx <= byte_idx + 8'h01;
                state    <= smb_pkg::SMB_RD;
              end
              else
              begin
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
                state   <= smb_pkg::SMB_WR;
              end
            end
          end
          smb_pkg::SMB_WR:
          begin
            if (line.scl_rise)
            begin
              shreg   <= {shreg[6:0], line.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (line.scl_fall && got8)
            begin
              byte_idx <= byte_idx + 8'h01;
              state    <= smb_pkg::SMB_ACK;
              sda_oe   <= 1'b1;
              if (byte_idx == 8'h00)
              begin
                register_pointer <= shreg;
                cur_addr         <= shreg[6:0];
              end
              else if (register_pointer[7] && byte_idx == 8'h01)
                blk_len <= shreg;
              else if (!register_pointer[7] || byte_idx - 8'h02 < blk_len)
              begin
                reg_we    <= 1'b1;
                reg_waddr <= cur_addr;
                reg_wdata <= shreg;
                if (register_pointer[7])
                  cur_addr <= cur_addr + 7'h01;
              end
              else
              begin
                state  <= smb_pkg::SMB_SKIP; // beyond the host's count: no ack
                sda_oe <= 1'b0;
              end
            end
          end
          smb_pkg::SMB_RD:
          begin
            if (line.scl_fall)
            begin
              if (got8)
              begin
                sda_oe <= 1'b0;
                state  <= smb_pkg::SMB_RACK;
                if (register_pointer[7] && byte_idx != 8'h01)
                  cur_addr <= cur_addr + 7'h01;
              end
              else
              begin
                shreg   <= {shreg[6:0], 1'b0};
                sda_oe  <= ~shreg[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          smb_pkg::SMB_RACK:
          begin
            if (line.scl_rise)
              host_ack <= ~line.sda;
            else if (line.scl_fall)
            begin
              if (host_ack && more_rd)
              begin
                shreg    <= tx_byte;
                sda_oe   <= ~tx_byte[7];
                bit_cnt  <= 4'h1;
                byte_idx <= byte_idx + 8'h01;
                state    <= smb_pkg::SMB_RD;
              end
              else
                state <= smb_pkg::SMB_SKIP;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // block read count register and pec
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      block_read_byte_count <= smb_pkg::BLOCK_COUNT_RESET;
    else if (reg_we && reg_waddr == smb_pkg::REG_BLOCK_COUNT)
      block_read_byte_count <= reg_wdata;
  end

  logic [7:0] crc;

  // pec_ok: last received byte equals the crc of everything before it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || line.start)
    begin
      crc    <= smb_pkg::CRC_INIT;
      pec_ok <= 1'b0;
    end
    else if (byte_done)
    begin
      crc    <= crc8(crc, shreg);
      pec_ok <= shreg == crc;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_MODE_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strap_done |-> arp_mode == strap_id_bits[2])
    else $error("mode does not follow strap level");
  AST_FD_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strap_done && !arp_mode |=> own_addr == 7'h50 + {4'h0, strap_id_bits})
    else $error("fixed address wrong");
  AST_VS_FIELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arp_mode |-> udid[18:16] == strap_id_bits && udid[15:0] == lfsr)
    else $error("vendor field wrong");
  AST_UDID_FIXED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    udid[127:120] == 8'hC1 && udid[79:64] == 16'h0004 && udid[63:32] == 32'h0)
    else $error("udid constant field wrong");
  AST_STRAP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strap_done |=> $stable(strap_id_bits) && strap_done)
    else $error("strap changed after capture");
  AST_FD_NO_ASSIGN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strap_done && !arp_mode && $past(strap_done) |=> $stable(own_addr))
    else $error("fixed address moved");
  AST_ACK_MATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == smb_pkg::SMB_ADDR && line.scl_fall && got8 && !line.start && !line.stop
    |=> (sda_oe && state == smb_pkg::SMB_ACK) == ($past(shreg[7:1]) == own_addr))
    else $error("address ack wrong");
  AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state inside {smb_pkg::SMB_IDLE, smb_pkg::SMB_ADDR, smb_pkg::SMB_WR, smb_pkg::SMB_RACK}
    |-> !sda_oe)
    else $error("sda driven outside ack or read data");
  AST_PTR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == smb_pkg::SMB_WR && byte_done && byte_idx == 8'h00 && !line.start && !line.stop
    |=> register_pointer == $past(shreg) ##1 !reg_we)
    else $error("pointer not loaded from first byte");

endmodule

// [smb_pkg.sv]
// Purpose: shared constants for the smbus slave addressing port
// Assumes: 10 MHz system clock, strap level already digitised to 3 bits
// Notes:   version, vendor id and device id live as top-level parameters
package smb_pkg;

  // ---------------------------------------------------------------
  // strap decoding
  // ---------------------------------------------------------------
  localparam logic [2:0] STRAP_ARP_MIN   = 3'h4;
  localparam logic [6:0] FD_ADDR_BASE    = 7'h50;
  localparam logic [6:0] ARP_ADDR_RESET  = 7'h61;

  // ---------------------------------------------------------------
  // registers and udid fields
  // ---------------------------------------------------------------
  localparam logic [6:0]  REG_BLOCK_COUNT   = 7'h00;
  localparam logic [7:0]  BLOCK_COUNT_RESET = 8'h01;
  localparam logic [7:0]  UDID_CAPS         = 8'hC1;
  localparam logic [15:0] UDID_INTERFACE    = 16'h0004;
  localparam logic [15:0] UDID_SUBSYS       = 16'h0000;
  localparam logic [12:0] UDID_VS_PAD       = 13'h0000;

  // ---------------------------------------------------------------
  // pec and random generator
  // ---------------------------------------------------------------
  localparam logic [7:0]  CRC_POLY   = 8'h07;
  localparam logic [7:0]  CRC_INIT   = 8'h00;
  localparam logic [15:0] LFSR_SEED  = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS  = 16'hB400;

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    SMB_IDLE, SMB_ADDR, SMB_ACK, SMB_WR, SMB_RD, SMB_RACK, SMB_SKIP
  } smb_state_e;

endpackage

// [smb_line_if.sv]
// Purpose: bus conditions passed from the line sampler to the core
// Assumes: all signals on clk_sys, one-cycle pulses except sda
// Notes:   sda is the filtered, settled data level
interface smb_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport det  (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// [smb_line_sampler.sv]
// Purpose: synchronise scl and sda and find edges, start and stop
// Assumes: scl period far longer than six system clocks
// Notes:   a level change counts once stages two and three agree
module smb_line_sampler (
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  smb_line_if.det    line
);

  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_q;
  logic       sda_q;

  // ---------------------------------------------------------------
  // three-stage synchronisers, stage one feeds only stage two
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // settled levels: only move when the two later stages agree
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      if (scl_sync[1] == scl_sync[2])
        scl_q <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_q <= sda_sync[2];
    end
  end

  logic next_scl;
  logic next_sda;
  assign next_scl = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
  assign next_sda = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;

  // start: sda falls while scl high; stop: sda rises while scl high
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      line.scl_rise <= 1'b0;
      line.scl_fall <= 1'b0;
      line.start    <= 1'b0;
      line.stop     <= 1'b0;
      line.sda      <= 1'b1;
    end
    else
    begin
      line.scl_rise <= next_scl & ~scl_q;
      line.scl_fall <= ~next_scl & scl_q;
      line.start    <= scl_q & next_scl & sda_q & ~next_sda;
      line.stop     <= scl_q & next_scl & ~sda_q & next_sda;
      line.sda      <= next_sda;
    end
  end

endmodule

// [smb_host_model.sv]
// Purpose: behavioural smbus host that drives scl and pulls sda low
// Assumes: sda_bus is the resolved open-drain line with a pull-up
// Notes:   800 ns bit time, scl rests high between frames
module smb_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_bus
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ---------------------------------------------------------------
  // frame conditions
  // ---------------------------------------------------------------
  // the same sequence serves as a repeated start when scl is low
  task automatic start_cond();
  begin
    // scl stays low until the slave has let go of its ack, else a stop is seen
    #100 sda_low = 1'b0;
    #500 scl = 1'b1;
    #200 sda_low = 1'b1;
    #300 scl = 1'b0;
  end
  endtask

  task automatic stop_cond();
  begin
    #100 sda_low = 1'b1;
    #300 scl = 1'b1;
    #200 sda_low = 1'b0;
    #300;
  end
  endtask

  // ---------------------------------------------------------------
  // bits and bytes
  // ---------------------------------------------------------------
  // data moves early in the low phase; sampled late in the high phase
  // so the slave's delayed sda drive has settled
  task automatic bit_x(input logic b, output logic s);
  begin
    #100 sda_low = ~b;
    #450 scl = 1'b1;
    #225 s = sda_bus;
    #25 scl = 1'b0;
  end
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
  begin
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  end
  endtask

  task automatic read_byte(input logic last, output logic [7:0] d);
    logic s;
  begin
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(last, s);
  end
  endtask
endmodule

// [test_smb_slave_port.sv]
// Purpose: self-checking bench for the smbus slave addressing port
// Assumes: host model on the wire, register file modelled here
// Notes:   strap is re-applied through reset to cover every level
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_smb_slave_port;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clk_sys      = 1'b0;
  logic         rst_n        = 1'b0;
  logic [2:0]   strap_level  = 3'h0;
  logic         assign_valid = 1'b0;
  logic [6:0]   assign_addr  = 7'h00;
  logic         scl;
  logic         sda_low;
  logic         sda_bus;
  logic         sda_out;
  logic         sda_oe;
  logic         arp_mode;
  logic         reg_we;
  logic         pec_ok;
  logic [6:0]   own_addr;
  logic [6:0]   reg_raddr;
  logic [6:0]   reg_waddr;
  logic [127:0] udid;
  logic [7:0]   reg_rdata;
  logic [7:0]   reg_wdata;
  logic [7:0]   register_pointer;
  logic [7:0]   block_read_byte_count;
  logic [7:0]   regs [128];
  logic [7:0]   rd;
  logic [15:0]  rnd;
  logic [2:0]   lv;
  logic         ack;
  int           miscompares  = 0;
  int           compares     = 0;

  // ---------------------------------------------------------------
  // wire, clock, register file
  // ---------------------------------------------------------------
  assign sda_bus = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  assign reg_rdata = regs[reg_raddr];
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (reg_we)
      regs[reg_waddr] <= reg_wdata;

  smb_host_model host_u (.scl(scl), .sda_low(sda_low), .sda_bus(sda_bus));

  // identification values are arbitrary
  smb_slave_port #(.UDID_VERSION(8'h3C), .UDID_VENDOR(16'h1357), .UDID_DEVICE(16'h2468)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_level(strap_level), .assign_valid(assign_valid), .assign_addr(assign_addr),
    .arp_mode(arp_mode), .own_addr(own_addr), .udid(udid), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .register_pointer(register_pointer),
    .block_read_byte_count(block_read_byte_count), .pec_ok(pec_ok));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
  begin
    c = 8'h00;
    for (int k = 15; k >= 0; k--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
    return c;
  end
  endfunction

  task automatic do_reset(input logic [2:0] s);
  begin
    @(negedge clk_sys);
    rst_n = 1'b0;
    strap_level = s;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
  end
  endtask

  task automatic pulse_assign(input logic [6:0] a);
  begin
    @(negedge clk_sys);
    assign_addr = a;
    assign_valid = 1'b1;
    @(negedge clk_sys);
    assign_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
  end
  endtask

  task automatic wr_ok(input logic [7:0] d);
  begin
    host_u.write_byte(d, ack);
    `CHK("ack", 1'b1, ack)
  end
  endtask

  task automatic complete_run();
  begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  initial
  begin
    #3000000;
    miscompares++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    for (int k = 0; k < 128; k++)
      regs[k] = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      lv = 3'(i);
      do_reset(lv);
      `CHK("arp_mode", (lv >= 3'h4), arp_mode)
      `CHK("udid_code", (lv >= 3'h4) ? lv : 3'h0, udid[18:16])
      if (lv < 3'h4)
        `CHK("own_addr", 7'h50 + 7'(lv), own_addr)
    end
    `CHK("caps", 8'hC1, udid[127:120])
    `CHK("ids", 40'h3C13572468, udid[119:80])
    `CHK("iface", 16'h0004, udid[79:64])
    `CHK("subsys", 32'h00000000, udid[63:32])
    `CHK("vs_pad", 13'h0000, udid[31:19])
    `CHK("count_rst", 8'h01, block_read_byte_count)
    `CHK("arp_addr", smb_pkg::ARP_ADDR_RESET, own_addr)
    pulse_assign(7'h2D);
    `CHK("arp_assign", 7'h2D, own_addr)
    do_reset(3'h2);
    strap_level = 3'h5;
    pulse_assign(7'h2D);
    `CHK("fd_addr", 7'h52, own_addr)
    `CHK("fd_mode", 1'b0, arp_mode)
    // write byte to register 0x05
    host_u.start_cond();
    wr_ok(8'hA4);
    wr_ok(8'h05);
    wr_ok(8'hA5);
    host_u.stop_cond();
    `CHK("pointer", 8'h05, register_pointer)
    `CHK("reg5", 8'hA5, regs[5])
    rnd = udid[15:0];
    // another address on the bus is left alone
    host_u.start_cond();
    host_u.write_byte(8'hA6, ack);
    `CHK("nack_addr", 1'b0, ack)
    host_u.stop_cond();
    // two reads with no pointer write between them
    repeat (2)
    begin
      host_u.start_cond();
      wr_ok(8'hA5);
      host_u.read_byte(1'b0, rd);
      `CHK("read_ack", 8'hA5, rd)
      host_u.read_byte(1'b1, rd);
      `CHK("read_last", 8'hA5, rd)
      host_u.stop_cond();
    end
    // send byte followed by a pec byte
    host_u.start_cond();
    wr_ok(8'hA4);
    wr_ok(8'h07);
    wr_ok(crc8(16'hA407));
    host_u.stop_cond();
    `CHK("send_ptr", 8'h07, register_pointer)
    `CHK("pec_ok", 1'b1, pec_ok)
    // block write of two bytes, a third is refused
    host_u.start_cond();
    wr_ok(8'hA4);
    wr_ok(8'h83);
    wr_ok(8'h02);
    wr_ok(8'h11);
    wr_ok(8'h22);
    host_u.write_byte(8'h33, ack);
    `CHK("blk_over", 1'b0, ack)
    host_u.stop_cond();
    `CHK("reg3", 8'h11, regs[3])
    `CHK("reg4", 8'h22, regs[4])
    // block read length from the count register
    host_u.start_cond();
    wr_ok(8'hA4);
    wr_ok(8'h00);
    wr_ok(8'h02);
    host_u.stop_cond();
    `CHK("count", 8'h02, block_read_byte_count)
    host_u.start_cond();
    wr_ok(8'hA4);
    wr_ok(8'h83);
    host_u.start_cond();
    wr_ok(8'hA5);
    host_u.read_byte(1'b0, rd);
    `CHK("blk_cnt", 8'h02, rd)
    host_u.read_byte(1'b0, rd);
    `CHK("blk_d1", 8'h11, rd)
    host_u.read_byte(1'b1, rd);
    `CHK("blk_d2", 8'h22, rd)
    host_u.stop_cond();
    `CHK("rand_hold", rnd, udid[15:0])
    complete_run();
  end
endmodule
